// >>> rtl/uic_pkg.sv
package uic_pkg;

  // bus decode width and register byte addresses
  localparam int unsigned ADDR_W   = 8;
  localparam logic [7:0]  OFS_CTL  = 8'h00;
  localparam logic [7:0]  OFS_TXD  = 8'h04;
  localparam logic [7:0]  OFS_RXD  = 8'h08;
  localparam logic [7:0]  OFS_INTF = 8'h0c;
  localparam logic [7:0]  OFS_INTE = 8'h10;

  // channel control fields
  localparam int unsigned CTL_EN   = 0;
  localparam int unsigned CTL_SRST = 1;

  // status and cause flag positions
  localparam int unsigned ST_RXACT = 9;
  localparam int unsigned ST_TXACT = 8;
  localparam int unsigned C_TEND   = 6;
  localparam int unsigned C_FE     = 5;
  localparam int unsigned C_PE     = 4;
  localparam int unsigned C_OE     = 3;
  localparam int unsigned C_RB2    = 2;
  localparam int unsigned C_RB1    = 1;
  localparam int unsigned C_TBE    = 0;
  localparam int unsigned CAUSE_W  = 7;
  localparam int unsigned STICKY_W = 4;

  // reset values
  localparam logic [6:0]  INTE_RST = 7'h00;
  localparam logic [3:0]  STK_RST  = 4'h0;
  localparam logic [7:0]  TXD_RST  = 8'h00;
  localparam logic [31:0] RD_RST   = 32'h0000_0000;

  // soft reset processing time and its cycle count
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned SRST_TIME_NS  = 32;
  localparam int unsigned SRST_CYC_DEF  =
    (SRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SRST_CNT_W    = 4;

  // receive buffer shape
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned RXF_DEPTH = 2;

  // ahb-lite encodings
  localparam logic        HRESP_OKAY = 1'b0;

  // bus slave phase
  typedef enum logic
  {
    UIC_BUS_IDLE = 1'b0,
    UIC_BUS_DATA = 1'b1
  } uic_bus_type;

  // framing engine to register block
  typedef struct packed
  {
    logic       tx_busy;
    logic       tx_load;
    logic       tx_end;
    logic       rx_busy;
    logic       rx_done;
    logic [7:0] rx_data;
    logic       rx_fe;
    logic       rx_pe;
  } uic_eng_in_type;

  // register block to framing engine
  typedef struct packed
  {
    logic       run;
    logic       srst;
    logic       tx_valid;
    logic [7:0] tx_data;
  } uic_eng_out_type;

endpackage

// >>> rtl/uic_rx_fifo.sv
module uic_rx_fifo
#(
  parameter int unsigned WIDTH = uic_pkg::DATA_W,
  parameter int unsigned DEPTH = uic_pkg::RXF_DEPTH
)
(
  // clock and reset
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  // control
  input  wire logic                       i_clr,
  input  wire logic                       i_push,
  input  wire logic [WIDTH-1:0]           i_data,
  input  wire logic                       i_pop,
  // state
  output logic      [WIDTH-1:0]           o_head,
  output logic      [$clog2(DEPTH+1)-1:0] o_count
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  // refuse depths the pointer wrap cannot serve
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_chk
    $error("uic_rx_fifo depth must be a power of two, at least 2");
  end

  typedef struct packed
  {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
  } uic_fifo_st_type;

  uic_fifo_st_type st_reg;
  uic_fifo_st_type st_next;

  logic do_push;
  logic do_pop;

  // push refused when full unless a pop frees room
  always_comb
  begin
    st_next = st_reg;
    do_pop  = i_pop && (st_reg.cnt != '0);
    do_push = i_push && ((st_reg.cnt != CW'(DEPTH)) || do_pop);
    if (do_push)
    begin
      st_next.mem[st_reg.wp] = i_data;
      st_next.wp             = st_reg.wp + 1'b1;
    end
    if (do_pop)
    begin
      st_next.rp = st_reg.rp + 1'b1;
    end
    if (do_push && !do_pop)
    begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
    else if (do_pop && !do_push)
    begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
    if (i_clr)
    begin
      st_next.wp  = '0;
      st_next.rp  = '0;
      st_next.cnt = '0;
    end
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // oldest entry first
  assign o_head  = st_reg.mem[st_reg.rp];
  assign o_count = st_reg.cnt;

endmodule

// >>> rtl/uic_regs.sv
// Function
// - writing one to soft reset clears flags and buffers, keeps enable
// - soft reset bit reads one until done
// - unit enable runs channel, zero stops it
// - receive data read returns oldest fifo entry
// - bit nine shows receiver active
// - bit eight shows transmitter active
// - seven cause flags at bits six to zero
// - done and overrun flags cleared writing one
// - error flags cleared by one or read
// - buffer full flags cleared only by read or soft reset
// - empty flag resets one, cleared by write
// - enable bits six to zero, reset zero
// - irq only for enabled set flag
module uic_regs
#(
  parameter int unsigned SRST_CYCLES = uic_pkg::SRST_CYC_DEF
)
(
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  // ahb-lite slave
  input  wire logic                   i_hsel,
  input  wire logic [31:0]            i_haddr,
  input  wire logic [1:0]             i_htrans,
  input  wire logic                   i_hwrite,
  input  wire logic [2:0]             i_hsize,
  input  wire logic [31:0]            i_hwdata,
  input  wire logic                   i_hready,
  output logic                        o_hreadyout,
  output logic                        o_hresp,
  output logic      [31:0]            o_hrdata,
  // framing engine
  input  wire uic_pkg::uic_eng_in_type  i_eng,
  output uic_pkg::uic_eng_out_type      o_eng,
  // interrupt request
  output logic                        o_irq
);

  localparam int unsigned CW = $clog2(uic_pkg::RXF_DEPTH + 1);

  // soft reset count must fit its counter
  if (SRST_CYCLES < 1 ||
      SRST_CYCLES >= (1 << uic_pkg::SRST_CNT_W))
  begin : g_chk
    $error("uic_regs soft reset cycles out of range");
  end

  typedef struct packed
  {
    uic_pkg::uic_bus_type            bus;
    logic                            hready;
    logic [31:0]                     hrdata;
    logic [uic_pkg::ADDR_W-1:0]      addr;
    logic                            wr;
    logic                            en;
    logic [uic_pkg::SRST_CNT_W-1:0]  srst_cnt;
    logic [7:0]                      txd;
    logic                            tx_full;
    logic [uic_pkg::STICKY_W-1:0]    sticky;
    logic [uic_pkg::CAUSE_W-1:0]     inte;
    logic                            rx_act;
    logic                            tx_act;
    logic                            irq;
    logic                            eng_run;
    logic                            eng_srst;
  } uic_st_type;

  uic_st_type st_reg;
  uic_st_type st_next;

  // reset release synchroniser
  logic rst_meta_reg;
  logic rst_n_reg;

  // receive buffer wiring
  logic            fifo_clr;
  logic            fifo_push;
  logic            fifo_pop;
  logic [7:0]      fifo_head;
  logic [CW-1:0]   fifo_cnt;

  // decode and event terms
  logic                        addr_sel;
  logic                        rx_full;
  logic                        rx_keep;
  logic [uic_pkg::CAUSE_W-1:0] cause;
  logic [31:0]                 rd_word;
  logic [31:0]                 wdat;

  // two-stage release of the asynchronous reset
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rst_meta_reg <= 1'b0;
      rst_n_reg    <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n_reg    <= rst_meta_reg;
    end
  end

  // two-entry receive buffer
  uic_rx_fifo
  #(
    .WIDTH (uic_pkg::DATA_W),
    .DEPTH (uic_pkg::RXF_DEPTH)
  )
  u_rx_fifo
  (
    .i_clk   (i_clk),
    .i_rst_n (rst_n_reg),
    .i_clr   (fifo_clr),
    .i_push  (fifo_push),
    .i_data  (i_eng.rx_data),
    .i_pop   (fifo_pop),
    .o_head  (fifo_head),
    .o_count (fifo_cnt)
  );

  // cause vector as software sees it
  always_comb
  begin
    cause                    = '0;
    cause[uic_pkg::C_TEND]   = st_reg.sticky[3];
    cause[uic_pkg::C_FE]     = st_reg.sticky[2];
    cause[uic_pkg::C_PE]     = st_reg.sticky[1];
    cause[uic_pkg::C_OE]     = st_reg.sticky[0];
    cause[uic_pkg::C_RB2]    =
      (fifo_cnt == CW'(uic_pkg::RXF_DEPTH));
    cause[uic_pkg::C_RB1]    = (fifo_cnt != '0);
    cause[uic_pkg::C_TBE]    = !st_reg.tx_full;
  end

  // read multiplexer, reserved bits zero
  always_comb
  begin
    rd_word = '0;
    unique case (st_reg.addr)
      uic_pkg::OFS_CTL:
      begin
        rd_word[uic_pkg::CTL_EN]   = st_reg.en;
        rd_word[uic_pkg::CTL_SRST] =
          (st_reg.srst_cnt != '0);
      end
      uic_pkg::OFS_TXD:
      begin
        rd_word[7:0] = st_reg.txd;
      end
      uic_pkg::OFS_RXD:
      begin
        if (fifo_cnt != '0)
        begin
          rd_word[7:0] = fifo_head;
        end
      end
      uic_pkg::OFS_INTF:
      begin
        rd_word[uic_pkg::ST_RXACT] = st_reg.rx_act;
        rd_word[uic_pkg::ST_TXACT] = st_reg.tx_act;
        rd_word[6:0]               = cause;
      end
      uic_pkg::OFS_INTE:
      begin
        rd_word[6:0] = st_reg.inte;
      end
      default:
      begin
        rd_word = '0;
      end
    endcase
  end

  // bus phases, register writes, events and soft reset
  always_comb
  begin
    st_next   = st_reg;
    fifo_pop  = 1'b0;
    fifo_clr  = 1'b0;
    fifo_push = 1'b0;
    rx_full   = 1'b0;
    rx_keep   = 1'b0;
    wdat      = i_hwdata;
    addr_sel  = i_hsel && i_hready && i_htrans[1];

    // address phase taken, data phase one wait state later
    unique case (st_reg.bus)
      uic_pkg::UIC_BUS_IDLE:
      begin
        st_next.hready = 1'b1;
        if (addr_sel)
        begin
          st_next.bus    = uic_pkg::UIC_BUS_DATA;
          st_next.addr   = i_haddr[uic_pkg::ADDR_W-1:0];
          st_next.wr     = i_hwrite;
          st_next.hready = 1'b0;
        end
      end
      uic_pkg::UIC_BUS_DATA:
      begin
        st_next.bus    = uic_pkg::UIC_BUS_IDLE;
        st_next.hready = 1'b1;
        if (!st_reg.wr)
        begin
          st_next.hrdata = rd_word;
          if (st_reg.addr == uic_pkg::OFS_RXD &&
              fifo_cnt != '0)
          begin
            fifo_pop          = 1'b1;
            st_next.sticky[2] = 1'b0;
            st_next.sticky[1] = 1'b0;
          end
        end
        else
        begin
          unique case (st_reg.addr)
            uic_pkg::OFS_CTL:
            begin
              st_next.en = wdat[uic_pkg::CTL_EN];
              if (wdat[uic_pkg::CTL_SRST])
              begin
                st_next.srst_cnt =
                  uic_pkg::SRST_CNT_W'(SRST_CYCLES);
              end
            end
            uic_pkg::OFS_TXD:
            begin
              st_next.txd     = wdat[7:0];
              st_next.tx_full = 1'b1;
            end
            uic_pkg::OFS_INTF:
            begin
              if (wdat[uic_pkg::C_TEND])
              begin
                st_next.sticky[3] = 1'b0;
              end
              if (wdat[uic_pkg::C_FE])
              begin
                st_next.sticky[2] = 1'b0;
              end
              if (wdat[uic_pkg::C_PE])
              begin
                st_next.sticky[1] = 1'b0;
              end
              if (wdat[uic_pkg::C_OE])
              begin
                st_next.sticky[0] = 1'b0;
              end
            end
            uic_pkg::OFS_INTE:
            begin
              st_next.inte = wdat[6:0];
            end
            default:
            begin
              st_next.inte = st_reg.inte;
            end
          endcase
        end
      end
    endcase

    // engine events count only while the channel runs
    if (st_reg.eng_run)
    begin
      // shift register took the buffered byte
      if (i_eng.tx_load && !(st_next.tx_full && !st_reg.tx_full))
      begin
        st_next.tx_full = 1'b0;
      end
      // stop bit sent with nothing waiting
      if (i_eng.tx_end && !st_reg.tx_full)
      begin
        st_next.sticky[3] = 1'b1;
      end
      // received byte stored unless both entries are full and no read pops one in that cycle
      if (i_eng.rx_done)
      begin
        rx_full = (fifo_cnt == CW'(uic_pkg::RXF_DEPTH)) &&
                  !fifo_pop;
        rx_keep = !rx_full;
        if (rx_full)
        begin
          st_next.sticky[0] = 1'b1;
        end
        if (rx_keep && i_eng.rx_fe)
        begin
          st_next.sticky[2] = 1'b1;
        end
        if (rx_keep && i_eng.rx_pe)
        begin
          st_next.sticky[1] = 1'b1;
        end
      end
      fifo_push      = rx_keep;
      st_next.rx_act = i_eng.rx_busy;
      st_next.tx_act = i_eng.tx_busy;
    end
    else
    begin
      st_next.rx_act = 1'b0;
      st_next.tx_act = 1'b0;
    end

    // soft reset holds the channel cleared while counting down
    if (st_reg.srst_cnt != '0)
    begin
      if (st_next.srst_cnt == st_reg.srst_cnt)
      begin
        st_next.srst_cnt = st_reg.srst_cnt - 1'b1;
      end
      st_next.sticky  = uic_pkg::STK_RST;
      st_next.tx_full = 1'b0;
      st_next.rx_act  = 1'b0;
      st_next.tx_act  = 1'b0;
      fifo_clr        = 1'b1;
    end

    // registered outputs to the engine and interrupt controller
    st_next.eng_srst = (st_next.srst_cnt != '0);
    st_next.eng_run  = st_next.en && !st_next.eng_srst;
    st_next.irq      = |(cause & st_reg.inte);
  end

  // single state register
  always_ff @(posedge i_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      st_reg          <= '0;
      st_reg.bus      <= uic_pkg::UIC_BUS_IDLE;
      st_reg.hready   <= 1'b1;
      st_reg.hrdata   <= uic_pkg::RD_RST;
      st_reg.txd      <= uic_pkg::TXD_RST;
      st_reg.sticky   <= uic_pkg::STK_RST;
      st_reg.inte     <= uic_pkg::INTE_RST;
      st_reg.tx_full  <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register, hresp tied to okay
  assign o_hreadyout    = st_reg.hready;
  assign o_hresp        = uic_pkg::HRESP_OKAY;
  assign o_hrdata       = st_reg.hrdata;
  assign o_irq          = st_reg.irq;
  assign o_eng.run      = st_reg.eng_run;
  assign o_eng.srst     = st_reg.eng_srst;
  assign o_eng.tx_valid = st_reg.tx_full;
  assign o_eng.tx_data  = st_reg.txd;

endmodule

// >>> sim/uic_regs_props.sv
module uic_regs_chk
#(
  parameter int unsigned SRST_CYCLES = uic_pkg::SRST_CYC_DEF
)
(
  // clock, reset and bus
  input wire logic                     i_clk,
  input wire logic                     i_arst_n,
  input wire logic                     i_hsel,
  input wire logic [31:0]              i_haddr,
  input wire logic [1:0]               i_htrans,
  input wire logic                     i_hwrite,
  input wire logic [2:0]               i_hsize,
  input wire logic [31:0]              i_hwdata,
  input wire logic                     i_hready,
  input wire logic                     o_hreadyout,
  input wire logic                     o_hresp,
  input wire logic [31:0]              o_hrdata,
  // engine and interrupt
  input wire uic_pkg::uic_eng_in_type  i_eng,
  input wire uic_pkg::uic_eng_out_type o_eng,
  input wire logic                     o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       take;
  logic [7:0] srst_cnt;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);
  // transfer accepted in an address phase
  assign take = i_hsel && i_hready && i_htrans[1];
  // length of the soft reset pulse
  always_ff @(posedge i_clk or negedge i_arst_n)
    if (!i_arst_n)
      srst_cnt <= 8'h00;
    else
      srst_cnt <= o_eng.srst ? srst_cnt + 8'h01 : 8'h00;
  property p_one_wait;
    take |=> !o_hreadyout ##1 o_hreadyout;
  endproperty
  property p_rsvd;
    o_hrdata[31:10] == 22'h0;
  endproperty
  property p_en_off;
    take && i_hwrite && i_haddr[7:0] == uic_pkg::OFS_CTL ##1 !i_hwdata[0]
      |-> ##[1:2] !o_eng.run;
  endproperty
  property p_srst_run;
    o_eng.srst && $past(o_eng.srst) |-> !o_eng.run;
  endproperty
  property p_srst_len;
    srst_cnt <= SRST_CYCLES + 1;
  endproperty
  property p_srst_txe;
    $fell(o_eng.srst) |-> !o_eng.tx_valid;
  endproperty
  property p_tx_write;
    take && i_hwrite && i_haddr[7:0] == uic_pkg::OFS_TXD |-> ##2
      (o_eng.tx_valid && o_eng.tx_data == $past(i_hwdata[7:0]));
  endproperty
  property p_tx_load;
    i_eng.tx_load && o_eng.run |=> !o_eng.tx_valid;
  endproperty
  property p_busy;
    take && !i_hwrite && i_haddr[7:0] == uic_pkg::OFS_INTF && o_eng.run
      ##1 o_eng.run |-> ##1
      o_hrdata[9:8] == $past({i_eng.rx_busy, i_eng.tx_busy}, 2);
  endproperty
  property p_irq_mask;
    take && i_hwrite && i_haddr[7:0] == uic_pkg::OFS_INTE
      ##1 i_hwdata[6:0] == 7'h00 |-> ##[1:3] !o_irq;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("bad wait");
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  a_en_off: assert property (p_en_off) else $error("run after disable");
  a_srst_run: assert property (p_srst_run) else $error("run in reset");
  a_srst_len: assert property (p_srst_len) else $error("reset long");
  a_srst_txe: assert property (p_srst_txe) else $error("buffer kept");
  a_tx_write: assert property (p_tx_write) else $error("tx byte lost");
  a_tx_load: assert property (p_tx_load) else $error("tx not empty");
  a_busy: assert property (p_busy) else $error("busy bits wrong");
  a_irq_mask: assert property (p_irq_mask) else $error("irq unmasked");
  c_srst: cover property ($rose(o_eng.srst));
  c_irq: cover property ($rose(o_irq));
  c_load: cover property (i_eng.tx_load && o_eng.run);
endmodule

// >>> sim/uic_eng_model.sv
module uic_eng_model
(
  input  wire logic                     i_clk,
  input  wire uic_pkg::uic_eng_out_type i_eng_out,
  output uic_pkg::uic_eng_in_type       o_eng
);
  timeunit 1ns;
  timeprecision 1ps;
  int tx_wait;
  int tx_len;
  // idle line, slow sender by default
  initial
  begin
    o_eng = '0;
    tx_wait = 0;
    tx_len = 12;
  end
  // take the buffered byte, send it, report the stop bit
  always @(posedge i_clk)
  begin
    // each pulse written once per edge
    o_eng.tx_end <= (tx_wait == 1);
    o_eng.tx_load <= (tx_wait == 0) && i_eng_out.run &&
                     i_eng_out.tx_valid && !o_eng.tx_load;
    if (tx_wait > 0)
    begin
      tx_wait <= tx_wait - 1;
      if (tx_wait == 1)
      begin
        o_eng.tx_busy <= 1'b0;
      end
    end
    else if (i_eng_out.run && i_eng_out.tx_valid && !o_eng.tx_load)
    begin
      o_eng.tx_busy <= 1'b1;
      tx_wait <= tx_len;
    end
  end
  // one received character with its error marks
  task automatic rx_byte(input logic [7:0] d, input logic fe, input logic pe);
    @(posedge i_clk);
    o_eng.rx_busy <= 1'b1;
    repeat (6) @(posedge i_clk);
    o_eng.rx_busy <= 1'b0;
    o_eng.rx_done <= 1'b1;
    o_eng.rx_data <= d;
    o_eng.rx_fe <= fe;
    o_eng.rx_pe <= pe;
    @(posedge i_clk);
    o_eng.rx_done <= 1'b0;
    o_eng.rx_data <= ~d;  // stale data scrambled
    o_eng.rx_fe <= ~fe;
    o_eng.rx_pe <= ~pe;
  endtask
endmodule

// >>> sim/test_uic_regs.sv
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("ERROR %0t: got %h exp %h", $time, got, exp); \
    end \
  end
module test_uic_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clk;
  logic                     arst_n;
  logic                     hsel;
  logic [31:0]              haddr;
  logic [1:0]               htrans;
  logic                     hwrite;
  logic [31:0]              hwdata;
  logic                     hready;
  logic                     hresp;
  logic [31:0]              hrdata;
  logic                     irq;
  logic [31:0]              rd;
  uic_pkg::uic_eng_in_type  eng_in;
  uic_pkg::uic_eng_out_type eng_out;
  int                       errors;
  int                       check_count;
  localparam logic [7:0] CTL = uic_pkg::OFS_CTL;
  localparam logic [7:0] TXD = uic_pkg::OFS_TXD;
  localparam logic [7:0] RXD = uic_pkg::OFS_RXD;
  localparam logic [7:0] INTF = uic_pkg::OFS_INTF;
  localparam logic [7:0] INTE = uic_pkg::OFS_INTE;
  uic_regs #(.SRST_CYCLES(4)) dut_u (.i_clk(clk), .i_arst_n(arst_n),
    .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_eng(eng_in), .o_eng(eng_out), .o_irq(irq));
  uic_eng_model eng_u (.i_clk(clk), .i_eng_out(eng_out), .o_eng(eng_in));
  // free running clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        errors++;
        $display("ERROR %0t: bus hang", $time);
        complete_run();
      end
      @(posedge clk);
    end
  endtask
  // one single word transfer
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(hresp, uic_pkg::HRESP_OKAY)
  endtask
  // read until the masked value shows up
  task automatic poll(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, a, 32'h0);
      n++;
    end while ((rd & m) !== e && n < 100);
    `CHK(rd & m, e)
  endtask
  // hang guard
  initial
  begin
    #500us;
    errors++;
    $display("ERROR %0t: run timed out", $time);
    complete_run();
  end
  // main sequence
  initial
  begin
    errors = 0;
    check_count = 0;
    {hsel, haddr, htrans, hwrite, hwdata, arst_n} = '0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(CTL, 32'h0);
    rd_chk(TXD, 32'h0);
    rd_chk(RXD, 32'h0);
    rd_chk(INTF, 32'h1);
    rd_chk(INTE, 32'h0);
    xfer(1'b1, 8'h20, 32'hffff_ffff);
    rd_chk(8'h20, 32'h0);
    xfer(1'b1, INTE, 32'hffff_ffff);
    rd_chk(INTE, 32'h7f);
    eng_u.rx_byte(8'h77, 1'b0, 1'b0);
    rd_chk(INTF, 32'h1);
    `CHK(irq, 1'b1)
    xfer(1'b1, INTE, 32'h2);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    xfer(1'b1, CTL, 32'h3);
    rd_chk(CTL, 32'h3);
    poll(CTL, 32'h2, 32'h0);
    rd_chk(CTL, 32'h1);
    eng_u.rx_byte(8'h11, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    rd_chk(INTF, 32'h3);
    xfer(1'b1, INTF, 32'h7);
    rd_chk(INTF, 32'h3);
    eng_u.rx_byte(8'h22, 1'b1, 1'b1);
    eng_u.rx_byte(8'h33, 1'b0, 1'b0);
    xfer(1'b0, INTF, 32'h0);
    `CHK(rd & 32'h3c, 32'h3c)
    rd_chk(RXD, 32'h11);
    xfer(1'b0, INTF, 32'h0);
    `CHK(rd & 32'h36, 32'h2)
    rd_chk(RXD, 32'h22);
    rd_chk(RXD, 32'h0);
    rd_chk(INTF, 32'h9);
    xfer(1'b1, INTF, 32'h8);
    rd_chk(INTF, 32'h1);
    eng_u.rx_byte(8'h44, 1'b1, 1'b0);
    xfer(1'b1, INTF, 32'h20);
    rd_chk(INTF, 32'h3);
    poll(INTF, 32'h1, 32'h1);
    xfer(1'b1, TXD, 32'ha5);
    poll(INTF, 32'h100, 32'h100);
    poll(INTF, 32'h40, 32'h40);
    rd_chk(INTF, 32'h43);
    rd_chk(TXD, 32'ha5);
    xfer(1'b1, INTF, 32'h40);
    rd_chk(INTF, 32'h3);
    fork
      eng_u.rx_byte(8'h55, 1'b0, 1'b0);
      poll(INTF, 32'h200, 32'h200);
    join
    xfer(1'b1, INTE, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    xfer(1'b1, INTE, 32'h7f);
    xfer(1'b1, CTL, 32'h0);
    xfer(1'b1, TXD, 32'h5a);
    xfer(1'b1, CTL, 32'h3);
    poll(CTL, 32'h2, 32'h0);
    rd_chk(INTF, 32'h1);
    rd_chk(RXD, 32'h0);
    rd_chk(INTE, 32'h7f);
    complete_run();
  end
endmodule
bind uic_regs uic_regs_chk #(.SRST_CYCLES(SRST_CYCLES)) chk_u (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize),
  .i_hwdata(i_hwdata), .i_hready(i_hready), .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp), .o_hrdata(o_hrdata), .i_eng(i_eng), .o_eng(o_eng),
  .o_irq(o_irq));
